// ---- clk_setup_defines.svh ----
// Register offsets, field positions, reset values and timing counts for the clock setup block
`ifndef CLK_SETUP_DEFINES_SVH
`define CLK_SETUP_DEFINES_SVH

// Register offsets (byte addresses on the host register port)
`define OFS_STRAP_PIN_STATUS 16'h0406
`define OFS_FIRST_OSC_CONTROL 16'h0408
`define OFS_SECOND_OSC_CONTROL 16'h040a
`define OFS_PLL_CONFIG_MAIN 16'h040c
`define OFS_PLL_CONFIG_TUNING 16'h040e
`define OFS_PLL_CONTROL 16'h0410

// Reset values
`define RST_FIRST_OSC_CONTROL 16'h0000
`define RST_SECOND_OSC_CONTROL 16'h0000
`define RST_PLL_CONFIG_MAIN 16'h0000
`define RST_PLL_CONFIG_TUNING 16'h0000
`define RST_PLL_CONTROL 16'h0000

// Field positions
`define STRAP_WIDTH 9
`define ENABLE_BIT 0
`define LOOP_FILTER_MSB 15
`define LOOP_FILTER_LSB 12
`define OSC_BAND_MSB 11
`define OSC_BAND_LSB 8
`define VCO_DIV_MSB 5
`define VCO_DIV_LSB 4
`define FB_MULT_MSB 3
`define FB_MULT_LSB 0

// Writable bit mask of the main PLL configuration word (bits 7-6 held at zero)
`define PLL_CONFIG_MAIN_MASK 16'hff3f

// Loop filter band codes
`define LOOP_FILTER_HIGH_REF 4'h8
`define LOOP_FILTER_LOW_REF 4'ha

// Oscillator band code limits
`define OSC_BAND_LOWEST 4'h1
`define OSC_BAND_HIGHEST 4'h8

// Synchroniser depth for strap pins
`define SYNC_STAGES 2

`endif

// ---- clk_setup_pkg.sv ----
// Types shared by the clock setup block
package clk_setup_pkg;

    // Host register address and data
    typedef logic [15:0] reg_addr_t;
    typedef logic [15:0] reg_word_t;

    // Strap pin vector
    typedef logic [8:0] strap_t;

    // Fields of the main PLL configuration word
    typedef struct packed {
        logic [3:0] loop_filter_band;
        logic [3:0] oscillator_band_select;
        logic [1:0] reserved_zero;
        logic [1:0] vco_divide_factor;
        logic [3:0] feedback_multiplier;
    } pll_config_main_s;

endpackage : clk_setup_pkg

// ---- strap_if.sv ----
// Carrier between strap capture and the register block
`timescale 1ns/1ps

interface strap_if;
    // Live strap level after synchronisation
    clk_setup_pkg::strap_t live;
    // Strap level frozen at reset release
    clk_setup_pkg::strap_t latched;

    modport producer (output live, output latched);
    modport consumer (input live, input latched);
endinterface : strap_if

// ---- strap_capture.sv ----
// Strap pin synchroniser and capture at reset release
`timescale 1ns/1ps
`include "clk_setup_defines.svh"

module strap_capture (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Raw strap pins
    input wire logic [`STRAP_WIDTH-1:0] config_strap_pins,
    // Results
    strap_if.producer straps
);

    // Synchroniser stages; the first is read only by the second
    logic [`STRAP_WIDTH-1:0] meta_q;
    logic [`STRAP_WIDTH-1:0] live_q;
    // Reset seen last cycle, to find the releasing edge
    logic in_reset_q;
    // Frozen configuration
    logic [`STRAP_WIDTH-1:0] latched_q;
    // Release edge detect
    wire release_edge = in_reset_q & ~srst;

    // Two-flop synchroniser runs through reset so the level is settled at release
    always_ff @(posedge core_clk)
    begin
        meta_q <= config_strap_pins;
        live_q <= meta_q;
    end

    // Track reset to detect its release
    always_ff @(posedge core_clk)
    begin
        in_reset_q <= srst;
    end

    // Capture once at release, ignore later pin changes
    always_ff @(posedge core_clk)
    begin
        if (release_edge)
        begin
            latched_q <= live_q;
        end
    end

    assign straps.live = live_q;
    assign straps.latched = latched_q;

endmodule : strap_capture

// ---- system_clock_setup_regs.sv ----
// Host registers for oscillator enables and system PLL configuration
`timescale 1ns/1ps
`include "clk_setup_defines.svh"

module system_clock_setup_regs (
    // Clock and resets
    input wire logic core_clk,
    input wire logic srst,
    input wire logic soft_reset,
    // Strap pins
    input wire logic [`STRAP_WIDTH-1:0] config_strap_pins,
    // Host register port
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // Strap configuration toward the rest of the chip
    output logic [`STRAP_WIDTH-1:0] strap_config,
    // Oscillator macro controls
    output logic first_oscillator_enable,
    output logic second_oscillator_enable,
    // System PLL macro controls
    output logic system_pll_enable,
    output logic [3:0] loop_filter_band,
    output logic [3:0] oscillator_band_select,
    output logic [1:0] vco_divide_factor,
    output logic [3:0] feedback_multiplier,
    output logic [15:0] system_pll_tuning,
    // Decoded ratios and code check
    output logic [3:0] vco_divide_ratio,
    output logic [4:0] feedback_ratio,
    output logic pll_config_reserved
);

    // Loop filter band code is legal
    function automatic logic loop_filter_legal(input logic [3:0] code);
        // Only the two reference ranges have a filter code
        loop_filter_legal = (code == `LOOP_FILTER_HIGH_REF) || (code == `LOOP_FILTER_LOW_REF);
    endfunction : loop_filter_legal

    // Oscillator band code is legal
    function automatic logic osc_band_legal(input logic [3:0] code);
        // Eight consecutive bands, zero and the top codes are reserved
        osc_band_legal = (code >= `OSC_BAND_LOWEST) && (code <= `OSC_BAND_HIGHEST);
    endfunction : osc_band_legal

    // Divider code to factor, zero for the reserved code
    function automatic logic [3:0] divide_ratio(input logic [1:0] code);
        // Codes 1, 2 and 3 give 2, 4 and 8
        divide_ratio = (code == 2'h0) ? 4'h0 : 4'(4'h1 << code);
    endfunction : divide_ratio

    // Strap carrier
    strap_if straps ();

    // Strap synchroniser and capture
    strap_capture u_strap_capture (
        .core_clk(core_clk),
        .srst(srst),
        .config_strap_pins(config_strap_pins),
        .straps(straps)
    );

    // Register storage
    // First oscillator control word, only bit 0 kept
    logic [15:0] first_osc_q;
    // Second oscillator control word, only bit 0 kept
    logic [15:0] second_osc_q;
    // Main PLL configuration word, bits 7-6 held at zero
    logic [15:0] pll_main_q;
    // PLL tuning word, all sixteen bits kept
    logic [15:0] pll_tuning_q;
    // PLL control word, only bit 0 kept
    logic [15:0] pll_ctrl_q;
    // Read port
    // Read data, held until the next read
    logic [15:0] rdata_q;
    // Read answer pulse
    logic rvalid_q;
    // Output level registers
    // Strap snapshot toward the rest of the chip
    logic [`STRAP_WIDTH-1:0] strap_config_q;
    // Divider factor decoded from its code
    logic [3:0] vco_divide_ratio_q;
    // Feedback multiplier plus one
    logic [4:0] feedback_ratio_q;
    // A stored configuration code is reserved
    logic pll_config_reserved_q;

    // Address decode
    // Strap status word, read only
    wire hit_strap = (reg_addr == `OFS_STRAP_PIN_STATUS);
    // First oscillator control word
    wire hit_first_osc = (reg_addr == `OFS_FIRST_OSC_CONTROL);
    // Second oscillator control word
    wire hit_second_osc = (reg_addr == `OFS_SECOND_OSC_CONTROL);
    // Main PLL configuration word
    wire hit_pll_main = (reg_addr == `OFS_PLL_CONFIG_MAIN);
    // PLL tuning word
    wire hit_pll_tuning = (reg_addr == `OFS_PLL_CONFIG_TUNING);
    // PLL control word
    wire hit_pll_ctrl = (reg_addr == `OFS_PLL_CONTROL);

    // Config writes are ignored while the PLL runs
    wire pll_running = pll_ctrl_q[`ENABLE_BIT];
    // Open for config writes only while the PLL is powered down
    wire cfg_open = ~pll_running;

    // Write strobes
    // First oscillator word takes every write
    wire wr_first_osc = reg_wr & hit_first_osc;
    // Second oscillator word takes every write
    wire wr_second_osc = reg_wr & hit_second_osc;
    // Main config word takes writes only while open
    wire wr_pll_main = reg_wr & hit_pll_main & cfg_open;
    // Tuning word shares the same lock
    wire wr_pll_tuning = reg_wr & hit_pll_tuning & cfg_open;
    // Control word always writable so software can stop the PLL
    wire wr_pll_ctrl = reg_wr & hit_pll_ctrl;

    // Only bit 0 of enable registers is stored
    wire [15:0] enable_word = {15'h0000, reg_wdata[`ENABLE_BIT]};
    // Reserved bits 7-6 forced to zero on store
    wire [15:0] pll_main_word = reg_wdata & `PLL_CONFIG_MAIN_MASK;

    // Field view of the main configuration
    clk_setup_pkg::pll_config_main_s pll_fields;
    assign pll_fields = clk_setup_pkg::pll_config_main_s'(pll_main_q);

    // Code check over the stored fields
    wire fields_reserved = ~loop_filter_legal(pll_fields.loop_filter_band)
        | ~osc_band_legal(pll_fields.oscillator_band_select)
        | (pll_fields.vco_divide_factor == 2'h0);

    // Read mux; unmapped addresses read zero
    wire [15:0] read_word =
        hit_strap ? {7'h00, straps.live} :
        hit_first_osc ? first_osc_q :
        hit_second_osc ? second_osc_q :
        hit_pll_main ? pll_main_q :
        hit_pll_tuning ? pll_tuning_q :
        hit_pll_ctrl ? pll_ctrl_q :
        16'h0000;

    // First oscillator enable: hardware reset only
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            first_osc_q <= `RST_FIRST_OSC_CONTROL;
        end
        // Host write to the first oscillator word
        else if (wr_first_osc)
        begin
            first_osc_q <= enable_word;
        end
    end

    // Second oscillator enable
    always_ff @(posedge core_clk)
    begin
        if (srst || soft_reset)
        begin
            second_osc_q <= `RST_SECOND_OSC_CONTROL;
        end
        // Host write to the second oscillator word
        else if (wr_second_osc)
        begin
            second_osc_q <= enable_word;
        end
    end

    // PLL main configuration
    always_ff @(posedge core_clk)
    begin
        if (srst || soft_reset)
        begin
            pll_main_q <= `RST_PLL_CONFIG_MAIN;
        end
        // Host write while the PLL is powered down
        else if (wr_pll_main)
        begin
            pll_main_q <= pll_main_word;
        end
    end

    // PLL tuning word
    always_ff @(posedge core_clk)
    begin
        if (srst || soft_reset)
        begin
            pll_tuning_q <= `RST_PLL_CONFIG_TUNING;
        end
        // Host write while the PLL is powered down
        else if (wr_pll_tuning)
        begin
            pll_tuning_q <= reg_wdata;
        end
    end

    // PLL enable
    always_ff @(posedge core_clk)
    begin
        if (srst || soft_reset)
        begin
            pll_ctrl_q <= `RST_PLL_CONTROL;
        end
        // Host write to the PLL enable
        else if (wr_pll_ctrl)
        begin
            pll_ctrl_q <= enable_word;
        end
    end

    // Registered read data, one cycle after the read strobe
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end
        else
        begin
            // Answer pulse follows each read strobe
            rvalid_q <= reg_rd;
            // Data holds between reads
            rdata_q <= reg_rd ? read_word : rdata_q;
        end
    end

    // Strap snapshot toward the rest of the chip
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            strap_config_q <= '0;
        end
        else
        begin
            strap_config_q <= straps.latched;
        end
    end

    // Decoded levels toward the PLL
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            vco_divide_ratio_q <= 4'h0;
            feedback_ratio_q <= 5'h01;
            pll_config_reserved_q <= 1'b0;
        end
        else
        begin
            vco_divide_ratio_q <= divide_ratio(pll_fields.vco_divide_factor);
            feedback_ratio_q <= {1'b0, pll_fields.feedback_multiplier} + 5'h01;
            pll_config_reserved_q <= fields_reserved;
        end
    end

    // Outputs straight from flip-flops
    // Read port
    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    // Strap snapshot
    assign strap_config = strap_config_q;

    // Oscillator enables
    assign first_oscillator_enable = first_osc_q[`ENABLE_BIT];
    assign second_oscillator_enable = second_osc_q[`ENABLE_BIT];

    // PLL enable and configuration fields
    assign system_pll_enable = pll_ctrl_q[`ENABLE_BIT];
    assign loop_filter_band = pll_main_q[`LOOP_FILTER_MSB:`LOOP_FILTER_LSB];
    assign oscillator_band_select = pll_main_q[`OSC_BAND_MSB:`OSC_BAND_LSB];
    assign vco_divide_factor = pll_main_q[`VCO_DIV_MSB:`VCO_DIV_LSB];
    assign feedback_multiplier = pll_main_q[`FB_MULT_MSB:`FB_MULT_LSB];
    assign system_pll_tuning = pll_tuning_q;

    // Decoded ratios and code check
    assign vco_divide_ratio = vco_divide_ratio_q;
    assign feedback_ratio = feedback_ratio_q;
    assign pll_config_reserved = pll_config_reserved_q;

endmodule : system_clock_setup_regs

// ---- system_clock_setup_regs_chk.sv ----
// Concurrent checks on the clock setup register block ports
`timescale 1ns/1ps
`include "clk_setup_defines.svh"

module system_clock_setup_regs_chk (
    // Clock and resets
    input wire logic core_clk,
    input wire logic srst,
    input wire logic soft_reset,
    // Host register port
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_rvalid,
    // Macro controls
    input wire logic [8:0] strap_config,
    input wire logic first_oscillator_enable,
    input wire logic system_pll_enable,
    input wire logic [3:0] loop_filter_band,
    input wire logic [3:0] oscillator_band_select,
    input wire logic [1:0] vco_divide_factor,
    input wire logic [3:0] feedback_multiplier,
    // Decoded ratios
    input wire logic [3:0] vco_divide_ratio,
    input wire logic [4:0] feedback_ratio
);
    // Main configuration word rebuilt from the field outputs
    wire logic [15:0] cfg = {loop_filter_band, oscillator_band_select, 2'h0, vco_divide_factor, feedback_multiplier};
    // Write to the first oscillator control word
    wire logic wr_first = reg_wr && reg_addr == `OFS_FIRST_OSC_CONTROL;
    // Write to the main configuration word, no software reset alongside
    wire logic wr_cfg = reg_wr && reg_addr == `OFS_PLL_CONFIG_MAIN && !soft_reset;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    read_valid_a: assert property (reg_rvalid == $past(reg_rd))
        else $error("read answer not one cycle after request");
    first_write_a: assert property (wr_first |=> first_oscillator_enable == $past(reg_wdata[0]))
        else $error("first oscillator enable not written");
    first_keep_a: assert property (soft_reset && !wr_first |=> $stable(first_oscillator_enable))
        else $error("first oscillator enable lost on software reset");
    pll_soft_clear_a: assert property (soft_reset |=> !system_pll_enable)
        else $error("pll enable survived software reset");
    cfg_write_a: assert property (!system_pll_enable && wr_cfg
        |=> cfg == ($past(reg_wdata) & `PLL_CONFIG_MAIN_MASK))
        else $error("configuration fields not written");
    cfg_lock_a: assert property (system_pll_enable && wr_cfg |=> $stable(cfg))
        else $error("configuration changed while pll running");
    strap_frozen_a: assert property (!srst [*4] |-> $stable(strap_config))
        else $error("strap snapshot changed after capture");
    fb_ratio_a: assert property (feedback_ratio == {1'b0, $past(feedback_multiplier)} + 5'h01)
        else $error("feedback ratio not multiplier plus one");
    div_ratio_a: assert property (vco_divide_factor != 2'h0
        |=> vco_divide_ratio == (4'h1 << $past(vco_divide_factor)))
        else $error("divide ratio wrong for code");

    // Main scenarios reached
    cover property (wr_first && reg_wdata[0]);
    cover property (system_pll_enable && wr_cfg);
    cover property (soft_reset && first_oscillator_enable);
endmodule : system_clock_setup_regs_chk

bind system_clock_setup_regs system_clock_setup_regs_chk system_clock_setup_regs_chk_inst (.core_clk, .srst,
    .soft_reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rvalid, .strap_config, .first_oscillator_enable,
    .system_pll_enable, .loop_filter_band, .oscillator_band_select, .vco_divide_factor, .feedback_multiplier,
    .vco_divide_ratio, .feedback_ratio);

// ---- tb.sv ----
// Self-checking testbench for the clock setup register block
`timescale 1ns/1ps
`include "clk_setup_defines.svh"

module tb;
    // Stimulus and observed outputs
    logic core_clk, srst, soft_reset, reg_wr, reg_rd, reg_rvalid, pll_config_reserved;
    logic first_oscillator_enable, second_oscillator_enable, system_pll_enable;
    logic [8:0] config_strap_pins, strap_config;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, system_pll_tuning;
    logic [3:0] loop_filter_band, oscillator_band_select, feedback_multiplier, vco_divide_ratio;
    logic [1:0] vco_divide_factor;
    logic [4:0] feedback_ratio;
    int error_cnt, checked;

    system_clock_setup_regs system_clock_setup_regs_inst (.core_clk, .srst, .soft_reset, .config_strap_pins,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .strap_config, .first_oscillator_enable,
        .second_oscillator_enable, .system_pll_enable, .loop_filter_band, .oscillator_band_select,
        .vco_divide_factor, .feedback_multiplier, .system_pll_tuning, .vco_divide_ratio, .feedback_ratio,
        .pll_config_reserved);

    // Print the counts and the verdict, then stop
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    // Compare a seen value with its expectation
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One host write, strobe held for one edge
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr

    // One host read with a bounded wait for the answer, then compare
    task automatic rc(input logic [15:0] a, input logic [15:0] exp);
        @(negedge core_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd = 1'b0;
        for (int n = 0; n < 4 && reg_rvalid !== 1'b1; n++)
            @(negedge core_clk);
        if (reg_rvalid !== 1'b1)
        begin
            error_cnt++;
            final_report();
        end
        else
        begin
            check($sformatf("reg %h", a), reg_rdata, exp);
        end
    endtask : rc

    // Reset values, strap snapshot and live strap status
    task automatic t_straps;
        rc(`OFS_FIRST_OSC_CONTROL, 16'h0000);
        rc(`OFS_SECOND_OSC_CONTROL, 16'h0000);
        rc(`OFS_PLL_CONFIG_MAIN, 16'h0000);
        rc(`OFS_PLL_CONTROL, 16'h0000);
        rc(16'h0402, 16'h0000);
        check("strap snapshot", {7'h00, strap_config}, 16'h00a5);
        config_strap_pins = 9'h15a;
        repeat (4) @(negedge core_clk);
        wr(`OFS_STRAP_PIN_STATUS, 16'hffff);
        rc(`OFS_STRAP_PIN_STATUS, 16'h015a);
        check("strap snapshot", {7'h00, strap_config}, 16'h00a5);
    endtask : t_straps

    // Oscillator enables, unused bits and software reset
    task automatic t_osc;
        wr(`OFS_FIRST_OSC_CONTROL, 16'hffff);
        check("first enable", {15'h0, first_oscillator_enable}, 16'h0001);
        repeat (8) @(negedge core_clk);
        rc(`OFS_FIRST_OSC_CONTROL, 16'h0001);
        wr(`OFS_SECOND_OSC_CONTROL, 16'hffff);
        repeat (8) @(negedge core_clk);
        check("second enable", {15'h0, second_oscillator_enable}, 16'h0001);
        soft_reset = 1'b1;
        @(negedge core_clk);
        soft_reset = 1'b0;
        check("first after soft reset", {15'h0, first_oscillator_enable}, 16'h0001);
        check("second after soft reset", {15'h0, second_oscillator_enable}, 16'h0000);
        rc(`OFS_FIRST_OSC_CONTROL, 16'h0001);
        rc(`OFS_SECOND_OSC_CONTROL, 16'h0000);
        // No panel output runs in this bench, so the oscillator may stop
        wr(`OFS_FIRST_OSC_CONTROL, 16'h0000);
        check("first enable", {15'h0, first_oscillator_enable}, 16'h0000);
    endtask : t_osc

    // Configuration codes, decoded ratios and the lock while running
    task automatic t_pll;
        logic [15:0] w;
        logic [15:0] f;
        logic [15:0] bad [4] = '{16'h8011, 16'h8911, 16'h8301, 16'h9311};
        wr(`OFS_PLL_CONFIG_MAIN, 16'hffff);
        rc(`OFS_PLL_CONFIG_MAIN, 16'hff3f);
        for (logic [1:0] c = 2'h1; c != 2'h0; c++)
        begin
            w = {c == 2'h2 ? 4'ha : 4'h8, c == 2'h3 ? 4'h8 : 4'h1, 2'h0, c, 4'(c) * 4'h5};
            wr(`OFS_PLL_CONFIG_MAIN, w);
            @(negedge core_clk);
            f = {loop_filter_band, oscillator_band_select, 2'h0, vco_divide_factor, feedback_multiplier};
            check("fields", f, w);
            check("divide ratio", {12'h0, vco_divide_ratio}, 16'h1 << c);
            check("feedback ratio", {11'h0, feedback_ratio}, 16'(c) * 16'h5 + 16'h1);
            check("code flag", {15'h0, pll_config_reserved}, 16'h0000);
        end
        foreach (bad[i])
        begin
            wr(`OFS_PLL_CONFIG_MAIN, bad[i]);
            @(negedge core_clk);
            check("code flag", {15'h0, pll_config_reserved}, 16'h0001);
        end
        // Factor 2 and a core frequency inside its band for a 50 MHz reference
        wr(`OFS_PLL_CONFIG_MAIN, 16'h8311);
        wr(`OFS_PLL_CONFIG_TUNING, 16'h0040);
        wr(`OFS_PLL_CONTROL, 16'hffff);
        rc(`OFS_PLL_CONTROL, 16'h0001);
        wr(`OFS_PLL_CONFIG_MAIN, 16'h0000);
        wr(`OFS_PLL_CONFIG_TUNING, 16'h1234);
        rc(`OFS_PLL_CONFIG_MAIN, 16'h8311);
        check("tuning", system_pll_tuning, 16'h0040);
        wr(`OFS_PLL_CONTROL, 16'h0000);
        wr(`OFS_PLL_CONFIG_TUNING, 16'h1234);
        rc(`OFS_PLL_CONFIG_TUNING, 16'h1234);
    endtask : t_pll

    // Free-running core clock
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Reset, scenarios, verdict; reserved offsets below the strap status are never written
    initial
    begin
        {srst, soft_reset, reg_wr, reg_rd} = 4'h8;
        config_strap_pins = 9'h0a5;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        srst = 1'b0;
        repeat (3) @(negedge core_clk);
        t_straps();
        t_osc();
        t_pll();
        final_report();
    end
endmodule : tb
